//--- logic/autoneg_result_pkg.sv
// Shared constants and carriers for the negotiation result register
package autoneg_result_pkg;

  // Register map
  localparam logic [4:0]  RESULT_REG_OFFSET   = 5'h11;
  localparam int          REG_ADDR_W          = 5;
  localparam int          REG_DATA_W          = 16;

  // Field positions
  localparam int          FLAGS_MSB           = 15;
  localparam int          FLAGS_LSB           = 12;
  localparam int          RESERVED_MSB        = 11;
  localparam int          RESERVED_LSB        = 9;
  localparam int          ADDRESS_MSB         = 8;
  localparam int          ADDRESS_LSB         = 4;
  localparam int          MONITOR_MSB         = 3;
  localparam int          MONITOR_LSB         = 0;

  // Values after reset
  localparam logic [3:0]  FLAGS_RESET         = 4'hf;
  localparam logic [2:0]  RESERVED_VALUE      = 3'h0;
  localparam logic [3:0]  MONITOR_RESET       = 4'h0;
  localparam logic [4:0]  ADDRESS_PRESET      = 5'h00;

  // One-hot flag values, highest bit first
  localparam logic [3:0]  FLAG_FAST_FULL      = 4'h8;
  localparam logic [3:0]  FLAG_FAST_HALF      = 4'h4;
  localparam logic [3:0]  FLAG_SLOW_FULL      = 4'h2;
  localparam logic [3:0]  FLAG_SLOW_HALF      = 4'h1;

  // Negotiation monitor codes
  localparam logic [3:0]  MON_IDLE            = 4'h0;
  localparam logic [3:0]  MON_ABILITY_MATCH   = 4'h1;
  localparam logic [3:0]  MON_ACK_MATCH       = 4'h2;
  localparam logic [3:0]  MON_ACK_FAIL        = 4'h3;
  localparam logic [3:0]  MON_CONSIST_MATCH   = 4'h4;
  localparam logic [3:0]  MON_CONSIST_FAIL    = 4'h5;
  localparam logic [3:0]  MON_PARALLEL_READY  = 4'h6;
  localparam logic [3:0]  MON_PARALLEL_FAIL   = 4'h7;
  localparam logic [3:0]  MON_COMPLETE        = 4'h8;

  // Serial address length
  localparam logic [2:0]  ADDRESS_BITS        = 3'h5;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
  } an_result_s;

  typedef struct packed {
    logic [3:0] flags;
    logic [2:0] reserved;
    logic [4:0] address;
    logic [3:0] monitor;
  } result_reg_s;

  // Resolved mode to one-hot flags
  function automatic logic [3:0] flags_of(input an_result_s res);
    logic [3:0] f;
    f = '0;
    case ({res.speed_100, res.full_duplex})
      2'b11:   f = FLAG_FAST_FULL; // see RULE1
      2'b10:   f = FLAG_FAST_HALF; // see RULE2
      2'b01:   f = FLAG_SLOW_FULL; // see RULE3
      default: f = FLAG_SLOW_HALF; // see RULE4
    endcase
    return f;
  endfunction : flags_of

endpackage : autoneg_result_pkg

//--- logic/result_flag_latch.sv
// Speed and duplex result flags, loaded when negotiation completes in negotiation mode
module result_flag_latch
  import autoneg_result_pkg::*;
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // Negotiation outcome
  input  wire logic       i_an_mode,
  input  wire logic       i_an_done,
  input  wire an_result_s i_an_result,
  // Flags
  output logic [3:0]      o_flags
);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flags <= FLAGS_RESET; // see RULE6
    end else if (i_an_done && i_an_mode) begin
      o_flags <= flags_of(i_an_result); // see RULE5
    end
  end

endmodule : result_flag_latch

//--- logic/address_serial.sv
// Serial match and shift-out of the management address, high bit first
module address_serial
  import autoneg_result_pkg::*;
#(
  parameter int ADDR_W = 5
)(
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // Own address
  input  wire logic [ADDR_W-1:0] i_address,
  // Incoming address bits
  input  wire logic              i_rx_start,
  input  wire logic              i_rx_valid,
  input  wire logic              i_rx_bit,
  // Outgoing address bits
  input  wire logic              i_tx_load,
  input  wire logic              i_tx_shift,
  // Results
  output logic                   o_match,
  output logic                   o_tx_bit
);

  if (ADDR_W != 5) begin : g_width_check
    $error("address_serial supports a five-bit address only");
  end

  logic [ADDR_W-1:0] rx_shift;
  logic [2:0]        rx_count;
  logic [ADDR_W-1:0] tx_shift;
  logic [ADDR_W-1:0] next_rx_shift;

  assign next_rx_shift = {rx_shift[ADDR_W-2:0], i_rx_bit};

  // Receive: first bit lands in the top position
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_shift <= '0;
      rx_count <= '0;
      o_match  <= 1'b0;
    end else if (i_rx_start) begin
      rx_count <= '0;
      o_match  <= 1'b0;
    end else if (i_rx_valid && rx_count < ADDRESS_BITS) begin
      rx_shift <= next_rx_shift; // see RULE9
      rx_count <= rx_count + 3'h1;
      if (rx_count == ADDRESS_BITS - 3'h1) begin
        o_match <= (next_rx_shift == i_address);
      end
    end
  end

  // Transmit: top bit goes first
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_shift <= '0;
      o_tx_bit <= 1'b0;
    end else if (i_tx_load) begin
      tx_shift <= i_address;
      o_tx_bit <= i_address[ADDR_W-1]; // see RULE9
    end else if (i_tx_shift) begin
      tx_shift <= {tx_shift[ADDR_W-2:0], 1'b0};
      o_tx_bit <= tx_shift[ADDR_W-2];
    end
  end

  property p_tx_msb_first;
    @(posedge i_core_clk) disable iff (i_rst)
      i_tx_load |=> (o_tx_bit == $past(i_address[ADDR_W-1]));
  endproperty
  a_tx_msb_first: assert property (p_tx_msb_first) // see RULE9
    else $error("first address bit out is not the top bit");

  property p_rx_match;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_rx_valid && !i_rx_start && rx_count == 3'h4) |=> (o_match == ($past(next_rx_shift) == $past(i_address)));
  endproperty
  a_rx_match: assert property (p_rx_match) // see RULE9
    else $error("address match does not follow received bits");

endmodule : address_serial

//--- logic/autoneg_result_status.sv
// Negotiation result, management address and monitor register
// What this block does
// RULE1 - The top flag is 1 exactly when negotiation resolved to 100 Mb/s full duplex.
// RULE2 - The second flag is 1 exactly when negotiation resolved to 100 Mb/s half duplex.
// RULE3 - The third flag is 1 exactly when negotiation resolved to 10 Mb/s full duplex.
// RULE4 - The fourth flag is 1 exactly when negotiation resolved to 10 Mb/s half duplex.
// RULE5 - The four flags change only when negotiation completes and are read together as one result.
// RULE6 - The flags come up as all ones, cannot be written, and mean nothing outside negotiation mode.
// RULE7 - The three bits between flags and address read as zero and ignore writes.
// RULE8 - Bits 8 to 4 hold the writable management address, preset from the strap inputs.
// RULE9 - The address travels on the serial link top bit first, and the manager must know it.
// RULE10 - The low four bits show the negotiation monitor code, read-only, zero after reset, codes 0 to 8.
// RULE11 - Monitor codes 4 to 8 report consistency, parallel detection and successful completion.
// RULE12 - Reading the register changes nothing in it.
module autoneg_result_status
  import autoneg_result_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  // Register port
  input  wire logic [REG_ADDR_W-1:0] i_reg_addr,
  input  wire logic [REG_DATA_W-1:0] i_reg_wdata,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  output logic      [REG_DATA_W-1:0] o_reg_rdata,
  // Negotiation engine
  input  wire logic                  i_an_mode,
  input  wire logic                  i_an_done,
  input  wire an_result_s            i_an_result,
  input  wire logic [3:0]            i_an_monitor,
  // Address straps
  input  wire logic [4:0]            i_address_strap,
  // Serial address path
  input  wire logic                  i_rx_start,
  input  wire logic                  i_rx_valid,
  input  wire logic                  i_rx_bit,
  input  wire logic                  i_tx_load,
  input  wire logic                  i_tx_shift,
  output logic                       o_addr_match,
  output logic                       o_tx_bit,
  // Live values
  output logic [3:0]                 o_result_flags,
  output logic [4:0]                 o_management_address
);

  logic        strap_pending;
  logic [3:0]  monitor_code;
  logic        reg_hit;
  result_reg_s reg_view;

  assign reg_hit = (i_reg_addr == RESULT_REG_OFFSET);

  // Result flags, loaded on completion only
  result_flag_latch u_flags (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_an_mode   (i_an_mode),
    .i_an_done   (i_an_done),
    .i_an_result (i_an_result),
    .o_flags     (o_result_flags)
  ); // see RULE5

  // Strap capture after reset release; a write in that cycle wins
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_pending        <= 1'b1;
      o_management_address <= ADDRESS_PRESET;
    end else begin
      strap_pending <= 1'b0;
      if (i_reg_wr && reg_hit) begin
        o_management_address <= i_reg_wdata[ADDRESS_MSB:ADDRESS_LSB]; // see RULE8
      end else if (strap_pending) begin
        o_management_address <= i_address_strap; // see RULE8
      end
    end
  end

  // Monitor code follows the engine; unknown codes are not taken
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      monitor_code <= MONITOR_RESET; // see RULE10
    end else if (i_an_monitor <= MON_COMPLETE) begin
      monitor_code <= i_an_monitor; // see RULE10 see RULE11
    end
  end

  always_comb begin
    reg_view.flags    = o_result_flags;
    reg_view.reserved = RESERVED_VALUE; // see RULE7
    reg_view.address  = o_management_address;
    reg_view.monitor  = monitor_code;
  end

  // Read data for one cycle only, no side effects
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd && reg_hit) begin
      o_reg_rdata <= reg_view; // see RULE12
    end else begin
      o_reg_rdata <= '0;
    end
  end

  address_serial #(
    .ADDR_W (5)
  ) u_serial (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_address  (o_management_address),
    .i_rx_start (i_rx_start),
    .i_rx_valid (i_rx_valid),
    .i_rx_bit   (i_rx_bit),
    .i_tx_load  (i_tx_load),
    .i_tx_shift (i_tx_shift),
    .o_match    (o_addr_match),
    .o_tx_bit   (o_tx_bit)
  ); // see RULE9

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_fast_full;
    (i_an_done && i_an_mode && i_an_result.speed_100 && i_an_result.full_duplex) |=> (o_result_flags == 4'h8);
  endproperty
  a_fast_full: assert property (p_fast_full) // see RULE1
    else $error("100 full result not shown as top flag alone");

  property p_fast_half;
    (i_an_done && i_an_mode && i_an_result.speed_100 && !i_an_result.full_duplex) |=> (o_result_flags == 4'h4);
  endproperty
  a_fast_half: assert property (p_fast_half) // see RULE2
    else $error("100 half result not shown as second flag alone");

  property p_slow_full;
    (i_an_done && i_an_mode && !i_an_result.speed_100 && i_an_result.full_duplex) |=> (o_result_flags == 4'h2);
  endproperty
  a_slow_full: assert property (p_slow_full) // see RULE3
    else $error("10 full result not shown as third flag alone");

  property p_slow_half;
    (i_an_done && i_an_mode && !i_an_result.speed_100 && !i_an_result.full_duplex) |=> (o_result_flags == 4'h1);
  endproperty
  a_slow_half: assert property (p_slow_half) // see RULE4
    else $error("10 half result not shown as fourth flag alone");

  property p_flags_hold;
    !(i_an_done && i_an_mode) |=> $stable(o_result_flags);
  endproperty
  a_flags_hold: assert property (p_flags_hold) // see RULE5
    else $error("result flags changed without completion");

  property p_flags_read_only;
    (i_reg_wr && reg_hit && !(i_an_done && i_an_mode)) |=> (o_result_flags == $past(o_result_flags));
  endproperty
  a_flags_read_only: assert property (p_flags_read_only) // see RULE6
    else $error("write altered the result flags");

  property p_reserved_zero;
    (i_reg_rd && reg_hit) |=> (o_reg_rdata[RESERVED_MSB:RESERVED_LSB] == 3'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // see RULE7
    else $error("reserved bits not read as zero");

  property p_address_write;
    (i_reg_wr && reg_hit) |=> ##1 (i_reg_rd && reg_hit && !i_reg_wr && !$past(i_reg_wr))
      |=> (o_reg_rdata[ADDRESS_MSB:ADDRESS_LSB] == $past(i_reg_wdata[ADDRESS_MSB:ADDRESS_LSB], 3));
  endproperty
  a_address_write: assert property (p_address_write) // see RULE8
    else $error("written address not read back");

  property p_address_direct;
    (i_reg_wr && reg_hit) |=> (o_management_address == $past(i_reg_wdata[ADDRESS_MSB:ADDRESS_LSB]));
  endproperty
  a_address_direct: assert property (p_address_direct) // see RULE8
    else $error("address field did not take the write");

  property p_monitor_read;
    (i_reg_rd && reg_hit) |=> (o_reg_rdata[MONITOR_MSB:MONITOR_LSB] == $past(monitor_code));
  endproperty
  a_monitor_read: assert property (p_monitor_read) // see RULE10
    else $error("monitor bits read wrong");

  property p_monitor_follow;
    (i_an_monitor <= 4'h8) |=> (monitor_code == $past(i_an_monitor));
  endproperty
  a_monitor_follow: assert property (p_monitor_follow) // see RULE11
    else $error("monitor code did not follow the engine");

  property p_read_no_effect;
    (i_reg_rd && !(i_an_done && i_an_mode) && !strap_pending) |=>
      ($stable(o_result_flags) && $stable(o_management_address));
  endproperty
  a_read_no_effect: assert property (p_read_no_effect) // see RULE12
    else $error("read changed register contents");

  // Flag, address, monitor, read port and serial path checks
  property p_flags_pattern;
    (o_result_flags == FLAGS_RESET) ||
      $onehot(o_result_flags);
  endproperty
  a_flags_pattern: assert property (p_flags_pattern) // see RULE5
    else $error("result flags neither reset value nor one-hot");

  property p_flags_done_onehot;
    (i_an_done && i_an_mode) |=>
      $onehot(o_result_flags);
  endproperty
  a_flags_done_onehot: assert property (p_flags_done_onehot) // see RULE5
    else $error("completed result is not a single flag");

  property p_flags_mode_gate;
    (i_an_done && !i_an_mode) |=>
      $stable(o_result_flags);
  endproperty
  a_flags_mode_gate: assert property (p_flags_mode_gate) // see RULE6
    else $error("flags loaded outside negotiation mode");

  property p_flags_read;
    (i_reg_rd && reg_hit) |=>
      (o_reg_rdata[FLAGS_MSB:FLAGS_LSB] == $past(o_result_flags));
  endproperty
  a_flags_read: assert property (p_flags_read) // see RULE5
    else $error("flag bits read wrong");

  property p_address_read;
    (i_reg_rd && reg_hit) |=>
      (o_reg_rdata[ADDRESS_MSB:ADDRESS_LSB] == $past(o_management_address));
  endproperty
  a_address_read: assert property (p_address_read) // see RULE8
    else $error("address bits read wrong");

  property p_strap_capture;
    ($fell(strap_pending) && !$past(i_reg_wr && reg_hit)) |->
      (o_management_address == $past(i_address_strap));
  endproperty
  a_strap_capture: assert property (p_strap_capture) // see RULE8
    else $error("address did not take the strap value");

  property p_address_hold;
    (!(i_reg_wr && reg_hit) && !strap_pending) |=>
      $stable(o_management_address);
  endproperty
  a_address_hold: assert property (p_address_hold) // see RULE8
    else $error("address changed without a write");

  property p_address_unmapped;
    (i_reg_wr && !reg_hit && !strap_pending) |=>
      $stable(o_management_address);
  endproperty
  a_address_unmapped: assert property (p_address_unmapped) // see RULE8
    else $error("write to another offset changed the address");

  property p_monitor_hold;
    (i_an_monitor > MON_COMPLETE) |=>
      $stable(monitor_code);
  endproperty
  a_monitor_hold: assert property (p_monitor_hold) // see RULE10
    else $error("unknown monitor code was taken");

  property p_rdata_idle;
    !i_reg_rd |=>
      (o_reg_rdata == '0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // see RULE12
    else $error("read data not zero without a read");

  property p_read_other_zero;
    (i_reg_rd && !reg_hit) |=>
      (o_reg_rdata == '0);
  endproperty
  a_read_other_zero: assert property (p_read_other_zero) // see RULE12
    else $error("read of another offset returned data");

  property p_rx_restart;
    i_rx_start |=>
      !o_addr_match;
  endproperty
  a_rx_restart: assert property (p_rx_restart) // see RULE9
    else $error("match not cleared by a restart");

  property p_match_hold;
    (!i_rx_start && !i_rx_valid) |=>
      $stable(o_addr_match);
  endproperty
  a_match_hold: assert property (p_match_hold) // see RULE9
    else $error("match changed without serial input");

  property p_tx_second_bit;
    i_tx_load ##1 (i_tx_shift && !i_tx_load) |=>
      (o_tx_bit == $past(o_management_address[3], 2));
  endproperty
  a_tx_second_bit: assert property (p_tx_second_bit) // see RULE9
    else $error("second address bit out is not bit three");

  property p_tx_hold;
    (!i_tx_load && !i_tx_shift) |=>
      $stable(o_tx_bit);
  endproperty
  a_tx_hold: assert property (p_tx_hold) // see RULE9
    else $error("outgoing bit changed without load or shift");

endmodule : autoneg_result_status

//--- testbench/mgmt_station.sv
// Station management model driving the register port and serial address path
module mgmt_station
  import autoneg_result_pkg::*;
(
  // Clock
  input  wire logic                  i_core_clk,
  // Register port
  output logic      [REG_ADDR_W-1:0] o_reg_addr,
  output logic      [REG_DATA_W-1:0] o_reg_wdata,
  output logic                       o_reg_wr,
  output logic                       o_reg_rd,
  input  wire logic [REG_DATA_W-1:0] i_reg_rdata,
  // Serial address path
  output logic                       o_rx_start,
  output logic                       o_rx_valid,
  output logic                       o_rx_bit,
  output logic                       o_tx_load,
  output logic                       o_tx_shift,
  input  wire logic                  i_tx_bit
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {o_reg_addr, o_reg_wdata, o_reg_wr, o_reg_rd} = '0;
    {o_rx_start, o_rx_valid, o_rx_bit, o_tx_load, o_tx_shift} = '0;
  end

  // Released lines show the inverse of their last value
  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    o_reg_wr    <= 1'b1;
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    @(posedge i_core_clk);
    o_reg_wr    <= 1'b0;
    o_reg_addr  <= ~a;
    o_reg_wdata <= ~d;
  endtask : reg_write

  task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    o_reg_rd   <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_core_clk);
    o_reg_rd   <= 1'b0;
    o_reg_addr <= ~a;
    #1;
    d = i_reg_rdata;
  endtask : reg_read

  // Address bits go out high bit first
  task automatic send_addr(input logic [4:0] a);
    @(posedge i_core_clk);
    o_rx_start <= 1'b1;
    for (int i = 4; i >= 0; i--) begin
      @(posedge i_core_clk);
      o_rx_start <= 1'b0;
      o_rx_valid <= 1'b1;
      o_rx_bit   <= a[i];
    end
    @(posedge i_core_clk);
    o_rx_valid <= 1'b0;
    o_rx_bit   <= ~a[0];
    #1;
  endtask : send_addr

  // First bit received lands in bit 4
  task automatic fetch_addr(output logic [4:0] a);
    @(posedge i_core_clk);
    o_tx_load <= 1'b1;
    for (int i = 4; i >= 0; i--) begin
      @(posedge i_core_clk);
      o_tx_load  <= 1'b0;
      o_tx_shift <= (i > 0);
      #1;
      a[i] = i_tx_bit;
    end
  endtask : fetch_addr

endmodule : mgmt_station

//--- testbench/tb_autoneg_result_status.sv
// Self-checking bench for the negotiation result register
module tb_autoneg_result_status
  import autoneg_result_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        an_mode  = 1'b1;
  logic        an_done  = 1'b0;
  an_result_s  an_result = '0;
  logic [3:0]  an_monitor = 4'h0;
  logic [4:0]  strap    = 5'h15;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        rx_start;
  logic        rx_valid;
  logic        rx_bit;
  logic        tx_load;
  logic        tx_shift;
  logic        addr_match;
  logic        tx_bit;
  logic [3:0]  result_flags;
  logic [4:0]  mgmt_addr;
  int          bad_count = 0;
  int          tests_run = 0;

  always #5 core_clk = ~core_clk;

  autoneg_result_status i_autoneg_result_status (
    .i_core_clk(core_clk), .i_rst(rst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_an_mode(an_mode),
    .i_an_done(an_done), .i_an_result(an_result), .i_an_monitor(an_monitor),
    .i_address_strap(strap), .i_rx_start(rx_start), .i_rx_valid(rx_valid), .i_rx_bit(rx_bit),
    .i_tx_load(tx_load), .i_tx_shift(tx_shift), .o_addr_match(addr_match), .o_tx_bit(tx_bit),
    .o_result_flags(result_flags), .o_management_address(mgmt_addr));

  mgmt_station i_mgmt_station (
    .i_core_clk(core_clk), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd), .i_reg_rdata(reg_rdata), .o_rx_start(rx_start), .o_rx_valid(rx_valid),
    .o_rx_bit(rx_bit), .o_tx_load(tx_load), .o_tx_shift(tx_shift), .i_tx_bit(tx_bit));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic pulse_done(input logic m, input an_result_s r);
    @(posedge core_clk);
    an_mode   <= m;
    an_done   <= 1'b1;
    an_result <= r;
    @(posedge core_clk);
    an_done   <= 1'b0;
    an_mode   <= 1'b1;
  endtask : pulse_done

  task automatic t_reset;
    logic [15:0] d;
    i_mgmt_station.reg_read(RESULT_REG_OFFSET, d);
    check("reset view", {4'hf, 3'h0, 5'h15, 4'h0}, d);
    check("reset flags", 16'h000f, {12'h000, result_flags});
    $display("t_reset done");
  endtask : t_reset

  task automatic t_flags;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      pulse_done(1'b1, an_result_s'(i[1:0]));
      i_mgmt_station.reg_read(RESULT_REG_OFFSET, d);
      check("result flags", 16'h0001 << i, {12'h000, d[15:12]});
    end
    pulse_done(1'b0, an_result_s'(2'b00));
    i_mgmt_station.reg_read(RESULT_REG_OFFSET, d);
    check("flags hold", 16'h0008, {12'h000, d[15:12]});
    $display("t_flags done");
  endtask : t_flags

  task automatic t_write;
    logic [15:0] d;
    i_mgmt_station.reg_write(RESULT_REG_OFFSET, 16'hffff);
    i_mgmt_station.reg_read(RESULT_REG_OFFSET, d);
    check("write all ones", {4'h8, 3'h0, 5'h1f, 4'h0}, d);
    i_mgmt_station.reg_write(RESULT_REG_OFFSET, 16'h0a50);
    i_mgmt_station.reg_write(5'h10, 16'h0000);
    i_mgmt_station.reg_read(5'h10, d);
    check("unmapped read", 16'h0000, d);
    check("address field", 16'h0005, {11'h000, mgmt_addr});
    $display("t_write done");
  endtask : t_write

  task automatic t_monitor;
    logic [15:0] d;
    for (int c = 0; c < 10; c++) begin
      @(posedge core_clk);
      an_monitor <= c[3:0];
      i_mgmt_station.reg_read(RESULT_REG_OFFSET, d);
      check("monitor code", (c < 9) ? c[15:0] : 16'h0008, {12'h000, d[3:0]});
    end
    $display("t_monitor done");
  endtask : t_monitor

  task automatic t_serial;
    logic [4:0] a;
    i_mgmt_station.send_addr(5'h05);
    check("match own", 16'h0001, {15'h0000, addr_match});
    i_mgmt_station.send_addr(5'h14);
    check("match reversed", 16'h0000, {15'h0000, addr_match});
    i_mgmt_station.fetch_addr(a);
    check("shifted address", 16'h0005, {11'h000, a});
    $display("t_serial done");
  endtask : t_serial

  task automatic t_noside;
    logic [15:0] d1;
    logic [15:0] d2;
    i_mgmt_station.reg_read(RESULT_REG_OFFSET, d1);
    i_mgmt_station.reg_read(RESULT_REG_OFFSET, d2);
    check("first read", {4'h8, 3'h0, 5'h05, 4'h8}, d1);
    check("second read", {4'h8, 3'h0, 5'h05, 4'h8}, d2);
    @(posedge core_clk);
    #1;
    check("read data idle", 16'h0000, reg_rdata);
    $display("t_noside done");
  endtask : t_noside

  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_flags();
    t_write();
    t_monitor();
    t_serial();
    t_noside();
    stop_test();
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    $display("time limit reached");
    stop_test();
  end

endmodule : tb_autoneg_result_status
